// ===== pbg_pkg.sv
// Package for the periodic N-pulse burst generator: register map and field layout.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
package pbg_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] OFS_MST_CTRL = 4'h0;
	localparam logic [3:0] OFS_MST_PSC = 4'h1;
	localparam logic [3:0] OFS_MST_ARR = 4'h2;
	localparam logic [3:0] OFS_SLV_CTRL = 4'h3;
	localparam logic [3:0] OFS_SLV_PSC = 4'h4;
	localparam logic [3:0] OFS_SLV_ARR = 4'h5;
	localparam logic [3:0] OFS_SLV_CCR = 4'h6;
	localparam logic [3:0] OFS_SLV_RCR = 4'h7;
	localparam logic [3:0] OFS_EVENT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'h9;
	localparam logic [3:0] OFS_MST_CNT = 4'ha;
	localparam logic [3:0] OFS_SLV_CNT = 4'hb;
	// Control register fields (both timers)
	localparam int unsigned B_RUN = 0;
	localparam int unsigned B_OPM = 1;
	localparam int unsigned B_DIR = 2;
	localparam int unsigned B_CMS_LO = 3;
	localparam int unsigned B_CMS_HI = 4;
	localparam int unsigned B_CKD_LO = 5;
	localparam int unsigned B_CKD_HI = 6;
	localparam int unsigned B_MMS_LO = 8;
	localparam int unsigned B_MMS_HI = 10;
	localparam int unsigned B_SMS_LO = 12;
	localparam int unsigned B_SMS_HI = 14;
	localparam int unsigned B_TS_LO = 16;
	localparam int unsigned B_TS_HI = 17;
	localparam int unsigned B_OCM_LO = 20;
	localparam int unsigned B_OCM_HI = 22;
	localparam int unsigned B_OCPE = 23;
	localparam int unsigned B_CCP = 24;
	localparam int unsigned B_CCE = 25;
	localparam int unsigned B_MOE = 26;
	// Event register bits (write one)
	localparam int unsigned B_UG_MST = 0;
	localparam int unsigned B_UG_SLV = 1;
	localparam logic [2:0] MMS_UPDATE = 3'h2;
	localparam logic [2:0] SMS_TRIGGER = 3'h6;
	localparam logic [1:0] TS_INTERNAL_TRIGGER_INPUT_ONE = 2'h1;
	localparam logic [2:0] OCM_PWM1 = 3'h6;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] PSC_RST = 16'h0000;
	localparam logic [15:0] ARR_RST = 16'hffff;
	localparam logic [15:0] CCR_RST = 16'h0000;
	localparam logic [7:0] RCR_RST = 8'h00;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pbg_req_t;
	typedef struct packed {
		logic [15:0] prescale_value;
		logic [15:0] reload_value;
		logic run;
		logic ug;
	} pbg_tb_cfg_t;
endpackage

// ===== pbg_time_base.sv
// Prescaled up-counting time base with preload and one-cycle update pulse.
// Assumes the parent supplies shadowed settings and a single clock.
`timescale 1ns/1ps
module pbg_time_base
	import pbg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pbg_tb_cfg_t cfg,
	output logic tick,
	output logic ovf,
	output logic [15:0] cnt_q,
	output logic [15:0] arr_act_q
);
	logic [15:0] pdiv_q;
	logic [15:0] psc_act_q;

	// Divider gives the count enable at clk / (psc + 1)
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pdiv_q <= 16'h0000;
		end else if (cfg.ug || !cfg.run) begin
			pdiv_q <= 16'h0000;
		end else if (pdiv_q >= psc_act_q) begin
			pdiv_q <= 16'h0000;
		end else begin
			pdiv_q <= pdiv_q + 16'h0001;
		end
	end

	assign tick = cfg.run && !cfg.ug && (pdiv_q >= psc_act_q);
	assign ovf = tick && (cnt_q >= arr_act_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 16'h0000;
		end else if (cfg.ug || ovf) begin
			cnt_q <= 16'h0000;
		end else if (tick) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// Preloaded values only land at an update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psc_act_q <= PSC_RST;
			arr_act_q <= ARR_RST;
		end else if (cfg.ug || ovf) begin
			psc_act_q <= cfg.prescale_value;
			arr_act_q <= cfg.reload_value;
		end
	end
endmodule

// ===== pbg_burst_gen.sv
// Top of the burst generator: master period timer chained to a slave pulse timer.
// Assumes software programs it over a strobe port with read data one cycle later.
`timescale 1ns/1ps
module pbg_burst_gen
	import pbg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pbg_req_t req,
	input wire logic [3:0] ext_trigger_in,
	output logic [31:0] rdata,
	output logic trigger_output,
	output logic ch1_out,
	output logic ch1_out_en_n
);
	logic [31:0] mst_ctrl_q;
	logic [31:0] slv_ctrl_q;
	logic [15:0] mst_psc_q, mst_arr_q, slv_psc_q, slv_arr_q, slv_ccr_q;
	logic [15:0] ccr_act_q;
	logic [7:0] rcr_q, rcr_act_q, rep_q;
	logic slv_run_q;
	logic trig_prev_q;
	logic ref_q;
	logic trigger_q;
	logic burst_done_q;
	logic [31:0] rdata_q;
	logic ug_mst, ug_slv;
	logic mst_tick, mst_ovf, slv_tick, slv_ovf;
	logic [15:0] mst_cnt, slv_cnt, mst_arr_act, slv_arr_act;
	logic [3:0] itr;
	logic trig_sel, trig_edge, slv_update, slv_start, up_mode;
	pbg_tb_cfg_t mst_cfg, slv_cfg;

	function automatic logic edge_up_mode(input logic [31:0] c);
		edge_up_mode = !c[B_DIR] && (c[B_CMS_HI:B_CMS_LO] == 2'h0)
			&& (c[B_CKD_HI:B_CKD_LO] == 2'h0);
	endfunction

	assign ug_mst = req.wr && (req.addr == OFS_EVENT) && req.wdata[B_UG_MST];
	assign ug_slv = req.wr && (req.addr == OFS_EVENT) && req.wdata[B_UG_SLV];

	// Register writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mst_ctrl_q <= CTRL_RST;
			mst_psc_q <= PSC_RST;
			mst_arr_q <= ARR_RST;
			slv_ctrl_q <= CTRL_RST;
			slv_psc_q <= PSC_RST;
			slv_arr_q <= ARR_RST;
			slv_ccr_q <= CCR_RST;
			rcr_q <= RCR_RST;
		end else if (req.wr) begin
			unique case (req.addr)
				OFS_MST_CTRL: mst_ctrl_q <= req.wdata;
				OFS_MST_PSC: mst_psc_q <= req.wdata[15:0];
				OFS_MST_ARR: mst_arr_q <= req.wdata[15:0];
				OFS_SLV_CTRL: slv_ctrl_q <= req.wdata;
				OFS_SLV_PSC: slv_psc_q <= req.wdata[15:0];
				OFS_SLV_ARR: slv_arr_q <= req.wdata[15:0];
				OFS_SLV_CCR: slv_ccr_q <= req.wdata[15:0];
				OFS_SLV_RCR: rcr_q <= req.wdata[7:0];
				default: ;
			endcase
		end
	end

	// Only edge-aligned up-counting with division by one is built; other codes stop it
	assign up_mode = edge_up_mode(mst_ctrl_q);
	// One driver for the whole struct keeps strict tools from seeing split drivers
	assign mst_cfg = '{prescale_value: mst_psc_q, reload_value: mst_arr_q,
		run: mst_ctrl_q[B_RUN] && up_mode, ug: ug_mst};

	pbg_time_base u_mst (
		.clk(clk),
		.rst(rst),
		.cfg(mst_cfg),
		.tick(mst_tick),
		.ovf(mst_ovf),
		.cnt_q(mst_cnt),
		.arr_act_q(mst_arr_act)
	);

	// Trigger out pulses only on update when source select says so
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trigger_q <= 1'b0;
		end else begin
			trigger_q <= (mst_ovf || ug_mst) && (mst_ctrl_q[B_MMS_HI:B_MMS_LO] == MMS_UPDATE);
		end
	end
	assign trigger_output = trigger_q;

	// Internal input one is the master's trigger; the rest come from outside
	assign itr = {ext_trigger_in[3:2], trigger_q, ext_trigger_in[0]};
	assign trig_sel = itr[slv_ctrl_q[B_TS_HI:B_TS_LO]];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trig_prev_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_sel;
		end
	end
	assign trig_edge = trig_sel && !trig_prev_q;
	assign slv_start = trig_edge && (slv_ctrl_q[B_SMS_HI:B_SMS_LO] == SMS_TRIGGER);

	assign slv_cfg = '{prescale_value: slv_psc_q, reload_value: slv_arr_q,
		run: slv_run_q && edge_up_mode(slv_ctrl_q), ug: ug_slv};

	pbg_time_base u_slv (
		.clk(clk),
		.rst(rst),
		.cfg(slv_cfg),
		.tick(slv_tick),
		.ovf(slv_ovf),
		.cnt_q(slv_cnt),
		.arr_act_q(slv_arr_act)
	);

	// Update fires only when the repeat counter has run out
	assign slv_update = slv_ovf && (rep_q == 8'h00);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rep_q <= 8'h00;
			rcr_act_q <= RCR_RST;
		end else if (ug_slv || slv_update) begin
			rep_q <= rcr_q;
			rcr_act_q <= rcr_q;
		end else if (slv_ovf) begin
			rep_q <= rep_q - 8'h01;
		end
	end

	// Counter run: set by software or trigger, cleared at burst end in single-pulse mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			slv_run_q <= 1'b0;
		end else if (req.wr && req.addr == OFS_SLV_CTRL) begin
			slv_run_q <= req.wdata[B_RUN];
		end else if (slv_start) begin
			slv_run_q <= 1'b1;
		end else if (slv_update && slv_ctrl_q[B_OPM]) begin
			slv_run_q <= 1'b0;
		end
	end

	// Compare preload: takes effect at update only when preload is on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ccr_act_q <= CCR_RST;
		end else if (!slv_ctrl_q[B_OCPE] || ug_slv || slv_update) begin
			ccr_act_q <= slv_ccr_q;
		end
	end

	// PWM mode 1 reference: high while count below compare, low when stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_q <= 1'b0;
		end else if (!slv_cfg.run || slv_update) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= (slv_ctrl_q[B_OCM_HI:B_OCM_LO] == OCM_PWM1) && (slv_cnt < ccr_act_q);
		end
	end

	// Polarity applied after gating, so a stopped pin idles at the CCP level; enables drive only ch1_out_en_n
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ch1_out <= 1'b0;
			ch1_out_en_n <= 1'b1;
		end else begin
			ch1_out <= ref_q ^ slv_ctrl_q[B_CCP];
			ch1_out_en_n <= !(slv_ctrl_q[B_MOE] && slv_ctrl_q[B_CCE]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			burst_done_q <= 1'b0;
		end else if (req.rd && req.addr == OFS_STATUS) begin
			burst_done_q <= slv_update; // Set wins over read-clear
		end else if (slv_update) begin
			burst_done_q <= 1'b1;
		end
	end

	// Read port, data one cycle after strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (req.rd) begin
			unique case (req.addr)
				OFS_MST_CTRL: rdata_q <= mst_ctrl_q;
				OFS_MST_PSC: rdata_q <= {16'h0000, mst_psc_q};
				OFS_MST_ARR: rdata_q <= {16'h0000, mst_arr_q};
				OFS_SLV_CTRL: rdata_q <= {slv_ctrl_q[31:1], slv_run_q};
				OFS_SLV_PSC: rdata_q <= {16'h0000, slv_psc_q};
				OFS_SLV_ARR: rdata_q <= {16'h0000, slv_arr_q};
				OFS_SLV_CCR: rdata_q <= {16'h0000, slv_ccr_q};
				OFS_SLV_RCR: rdata_q <= {24'h000000, rcr_q};
				OFS_STATUS: rdata_q <= {16'h0000, rep_q, 5'h00, burst_done_q, ref_q, slv_run_q};
				OFS_MST_CNT: rdata_q <= {16'h0000, mst_cnt};
				OFS_SLV_CNT: rdata_q <= {16'h0000, slv_cnt};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end else begin
			rdata_q <= 32'h0000_0000;
		end
	end
	assign rdata = rdata_q;
endmodule

// ===== pbg_burst_gen_props.sv
// Port checker for the burst generator top.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ps
module pbg_burst_gen_props
	import pbg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire pbg_req_t req,
	input wire logic [31:0] rdata,
	input wire logic trigger_output,
	input wire logic ch1_out,
	input wire logic ch1_out_en_n
);
	logic [31:0] ctrl_q;
	logic [15:0] arr_q;
	logic pin_en;
	// Shadows of slave writes; run bit self-clears, so it is never compared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			arr_q <= ARR_RST;
		end else if (req.wr) begin
			if (req.addr == OFS_SLV_CTRL) ctrl_q <= req.wdata;
			if (req.addr == OFS_SLV_ARR) arr_q <= req.wdata[15:0];
		end
	end
	assign pin_en = ctrl_q[B_CCE] & ctrl_q[B_MOE];
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// Three settled cycles cover the register stage ahead of the pin
	sequence s_off; !pin_en [*3]; endsequence
	sequence s_on; pin_en [*3]; endsequence
	AST_TRIG_ONE: assert property (trigger_output |=> !trigger_output)
		else $error("trigger pulse too long");
	AST_RD_IDLE: assert property (!req.rd |=> rdata == 32'h0)
		else $error("read data outside read slot");
	AST_EVT_RD: assert property (req.rd && req.addr == OFS_EVENT |=> rdata == 32'h0)
		else $error("event register reads nonzero");
	AST_UNMAP: assert property (req.rd && req.addr > OFS_SLV_CNT |=> rdata == 32'h0)
		else $error("unmapped read nonzero");
	AST_PIN_OFF: assert property (s_off |-> ch1_out_en_n)
		else $error("pin driven without both enables");
	AST_PIN_ON: assert property (s_on |-> !ch1_out_en_n)
		else $error("pin not driven with both enables");
	AST_ARR_RB: assert property (req.rd && req.addr == OFS_SLV_ARR |=> rdata == {16'h0, arr_q})
		else $error("slave reload readback wrong");
	AST_CTRL_RB: assert property (req.rd && req.addr == OFS_SLV_CTRL |=> rdata[31:1] == ctrl_q[31:1])
		else $error("slave control readback wrong");
endmodule
bind pbg_burst_gen pbg_burst_gen_props u_props (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
	.trigger_output(trigger_output), .ch1_out(ch1_out), .ch1_out_en_n(ch1_out_en_n));

// ===== pbg_sync_src.sv
// Foreign timer pulsing the unselected external sync lines.
// Assumes the bench shares the block's clock and reset.
`timescale 1ns/1ps
module pbg_sync_src (
	input wire logic clk,
	input wire logic rst,
	output logic [3:0] sync_q
);
	logic [5:0] cnt_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt_q <= 6'h00;
		else cnt_q <= cnt_q + 6'h01;
	end
	// Line one stays low: the master trigger owns input one
	assign sync_q = (cnt_q == 6'h25) ? 4'hd : 4'h0;
endmodule

// ===== test_periodic_n_pulse_burst_generator.sv
// Bench for the burst generator: register tasks, burst timing, pin enables.
// Assumes the sync-source model drives the external sync inputs.
`timescale 1ns/1ps
module test_periodic_n_pulse_burst_generator
	import pbg_pkg::*;
;
	// Single pulse, trigger from input one, PWM1, preload, both enables
	localparam logic [31:0] SCTL = 32'h06e1_6002;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pbg_req_t req = '0;
	logic [31:0] rdata;
	logic [3:0] sync;
	logic trig, pin, pin_en_n;
	int err_count = 0, compares = 0, i;
	always #4 clk = ~clk;
	pbg_burst_gen u_dut (.clk(clk), .rst(rst), .req(req), .ext_trigger_in(sync), .rdata(rdata),
		.trigger_output(trig), .ch1_out(pin), .ch1_out_en_n(pin_en_n));
	pbg_sync_src u_src (.clk(clk), .rst(rst), .sync_q(sync));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		chk(rdata & m, e);
		@(posedge clk);
	endtask
	// One master period from trigger to trigger; long wait caps a hang
	task automatic meas(input logic pol, input int ep, input int eh, input int er);
		int n = 0, h = 0, r = 0;
		logic last;
		#1;
		for (int k = 0; k < 1000 && trig !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		last = pin;
		do begin
			@(posedge clk);
			#1;
			n++;
			h += (pin !== pol);
			r += (pin !== pol && last === pol);
			last = pin;
		end while (trig !== 1'b1 && n < 1000);
		chk(n, ep);
		chk(h, eh);
		chk(r, er);
		chk({31'h0, pin}, {31'h0, pol});
		repeat (60) @(posedge clk);
	endtask
	task automatic results();
		$display("compares=%0d errors=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_MST_CTRL, '1, CTRL_RST);
		rd(OFS_SLV_ARR, '1, {16'h0, ARR_RST});
		rd(OFS_SLV_RCR, '1, {24'h0, RCR_RST});
		rd(OFS_EVENT, '1, 32'h0);
		rd(4'hf, '1, 32'h0);
		wr(OFS_SLV_ARR, 32'h9);
		rd(OFS_SLV_ARR, '1, 32'h9);
		wr(OFS_SLV_CCR, 32'h5);
		wr(OFS_MST_PSC, 32'h1);
		wr(OFS_MST_ARR, 32'h63);
		wr(OFS_EVENT, 32'h1);
		wr(OFS_MST_CTRL, 32'h201);
		for (i = 0; i < 4; i++) begin
			wr(OFS_SLV_RCR, i[0] ? 32'h2 : 32'h0);
			wr(OFS_SLV_CTRL, SCTL | ({31'h0, i[1]} << B_CCP));
			wr(OFS_EVENT, 32'h2);
			meas(i[1], 200, i[0] ? 15 : 5, i[0] ? 3 : 1);
		end
		rd(OFS_STATUS, 32'h7, 32'h4);
		rd(OFS_STATUS, 32'h7, 32'h0);
		wr(OFS_SLV_CTRL, SCTL & 32'hffff_8fff);
		meas(1'b0, 200, 0, 0);
		for (i = 0; i < 4; i++) begin
			wr(OFS_SLV_CTRL, 32'h00e1_0002 | ({30'h0, i[1:0]} << B_CCE));
			@(negedge clk);
			chk({31'h0, pin_en_n}, {31'h0, i != 3});
			@(posedge clk);
		end
		rd(OFS_SLV_CTRL, 32'hffff_fffe, 32'h06e1_0002);
		results();
	end
	initial begin
		#100000;
		err_count++;
		results();
	end
endmodule
